// ### lsic_pkg.sv
// constants shared by the sample input capture block
// How it works
// - capture sample bus on both clock edges
// - rising-edge frame marker resets fifo or syncs
// - falling-edge frame marker checked as block parity
// - sync strobe sampled on core clock rise
// - dual-sync strobe aligns divider and read pointer
// - strobe optional outside dual-sync mode
// - word or byte width; low bit is bit0 unless reversed
// - reverse control flips captured bit order
package lsic_pkg;
  // ==========================================
  // widths and depths
  localparam int unsigned BUS_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned DIV_W = 2;
  // ==========================================
  // counts and reset values
  localparam logic [PTR_W:0] PTR_RST = 4'h0;
  localparam logic [PTR_W:0] ALIGN_OFFSET = 4'h4;
  localparam logic [PTR_W:0] FULL_COUNT = 4'h8;
  localparam logic [DIV_W-1:0] DIV_RST = 2'h0;
  localparam logic [DIV_W-1:0] DIV_LAST = 2'h3;
  localparam logic [BUS_W-1:0] WORD_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
endpackage

// ### lsic_fifo_if.sv
// carrier between capture logic and sample fifo
`timescale 1ns/1ns
`default_nettype none
interface lsic_fifo_if;
  logic wr_en;
  logic [lsic_pkg::BUS_W-1:0] wr_data;
  logic clear;
  logic align;
  logic rd_en;
  logic [lsic_pkg::BUS_W-1:0] rd_data;
  logic rd_ok;
  logic full;
  logic empty;
  modport fifo(input wr_en, wr_data, clear, align, rd_en, output rd_data, rd_ok, full, empty);
  modport user(output wr_en, wr_data, clear, align, rd_en, input rd_data, rd_ok, full, empty);
endinterface
`default_nettype wire

// ### lsic_sample_fifo.sv
// sample fifo between bus-side writes and core-side reads
`timescale 1ns/1ns
`default_nettype none
module lsic_sample_fifo (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fifo side of the carrier
  lsic_fifo_if.fifo fif
);
  logic [lsic_pkg::BUS_W-1:0] mem [lsic_pkg::FIFO_DEPTH];
  logic [lsic_pkg::PTR_W:0] wr_ptr_reg;
  logic [lsic_pkg::PTR_W:0] rd_ptr_reg;
  logic [lsic_pkg::PTR_W:0] count;
  logic [lsic_pkg::BUS_W-1:0] rd_data_reg;
  logic rd_ok_reg;

  // ==========================================
  // occupancy, one clock so pointers compare directly
  assign count = wr_ptr_reg - rd_ptr_reg;
  assign fif.full = (count == lsic_pkg::FULL_COUNT);
  assign fif.empty = (count == lsic_pkg::PTR_RST);
  assign fif.rd_data = rd_data_reg;
  assign fif.rd_ok = rd_ok_reg;

  // write side, drops words while full
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= lsic_pkg::PTR_RST;
    end else if (fif.clear) begin
      wr_ptr_reg <= lsic_pkg::PTR_RST;
    end else if (fif.wr_en && !fif.full) begin
      wr_ptr_reg <= wr_ptr_reg + 4'h1;
    end
  end

  // storage array
  always_ff @(posedge clk) begin
    if (fif.wr_en && !fif.full && !fif.clear) begin
      mem[wr_ptr_reg[lsic_pkg::PTR_W-1:0]] <= fif.wr_data;
    end
  end

  // read side; alignment places reader a fixed distance behind writer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_reg <= lsic_pkg::PTR_RST;
      rd_data_reg <= lsic_pkg::WORD_RST;
      rd_ok_reg <= 1'b0;
    end else begin
      rd_ok_reg <= 1'b0;
      if (fif.clear) begin
        rd_ptr_reg <= lsic_pkg::PTR_RST;
      end else if (fif.align) begin
        rd_ptr_reg <= wr_ptr_reg - lsic_pkg::ALIGN_OFFSET;
      end else if (fif.rd_en && !fif.empty) begin
        rd_data_reg <= mem[rd_ptr_reg[lsic_pkg::PTR_W-1:0]];
        rd_ok_reg <= 1'b1;
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
    end
  end

  // ==========================================
  // checks
  a_full_holds_ptr: assert property (@(posedge clk) disable iff (sys_rst)
    (fif.full && !fif.clear && !fif.align && !fif.rd_en) |=> $stable(wr_ptr_reg))
    else $error("write pointer moved while fifo full");
  a_align_distance: assert property (@(posedge clk) disable iff (sys_rst)
    (fif.align && !fif.clear && !fif.wr_en) |=> (count == lsic_pkg::ALIGN_OFFSET))
    else $error("read pointer not aligned behind write pointer");
endmodule
`default_nettype wire

// ### lsic_capture.sv
// double-data-rate sample bus capture with frame, parity and strobe alignment
`timescale 1ns/1ns
`default_nettype none
module lsic_capture (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // sample bus from the data source
  input wire logic sample_bus_clock,
  input wire logic [15:0] sample_bus,
  input wire logic frame_marker,
  // converter side
  input wire logic converter_core_clock,
  input wire logic output_sync_strobe,
  // static configuration
  input wire logic byte_mode,
  input wire logic reverse_bus,
  input wire logic frame_is_sync,
  input wire logic dual_sync_mode,
  input wire logic parity_enable,
  input wire logic odd_parity,
  // results
  output logic [15:0] sample_out,
  output logic sample_valid,
  output logic frame_sync,
  output logic parity_error,
  output logic fifo_overflow,
  output logic divided_clock
);
  lsic_fifo_if fif ();

  logic bus_clk_prev_reg;
  logic core_clk_prev_reg;
  logic bus_rise;
  logic bus_fall;
  logic core_rise;
  logic [lsic_pkg::BUS_W-1:0] word_rev;
  logic [lsic_pkg::BUS_W-1:0] byte_rev;
  logic [lsic_pkg::BUS_W-1:0] bus_word;
  logic [lsic_pkg::BUS_W-1:0] rise_word_reg;
  logic [lsic_pkg::BUS_W-1:0] fall_word_reg;
  logic frame_rise_reg;
  logic frame_fall_reg;
  logic frame_start;
  logic wr_en_reg;
  logic [lsic_pkg::BUS_W-1:0] wr_data_reg;
  logic clear_reg;
  logic frame_sync_reg;
  logic parity_error_reg;
  logic strobe_reg;
  logic strobe_event;
  logic align_reg;
  logic [lsic_pkg::DIV_W-1:0] div_cnt_reg;
  logic rd_en_reg;
  logic [lsic_pkg::BUS_W-1:0] sample_out_reg;
  logic sample_valid_reg;
  logic fifo_overflow_reg;
  logic divided_clock_reg;

  // ==========================================
  // edge detection of the two incoming clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_clk_prev_reg <= 1'b0;
      core_clk_prev_reg <= 1'b0;
    end else begin
      bus_clk_prev_reg <= sample_bus_clock;
      core_clk_prev_reg <= converter_core_clock;
    end
  end

  assign bus_rise = sample_bus_clock && !bus_clk_prev_reg;
  assign bus_fall = !sample_bus_clock && bus_clk_prev_reg;
  assign core_rise = converter_core_clock && !core_clk_prev_reg;

  // ==========================================
  // bit reversal and width selection, one term per bit
  for (genvar i = 0; i < lsic_pkg::BUS_W; i++) begin : g_rev
    assign word_rev[i] = sample_bus[lsic_pkg::BUS_W-1-i];
    if (i < lsic_pkg::BYTE_W) begin : g_lo
      assign byte_rev[i] = sample_bus[lsic_pkg::BYTE_W-1-i];
    end else begin : g_hi
      assign byte_rev[i] = 1'b0;
    end
  end

  // byte mode ignores the upper pins
  always_comb begin
    if (byte_mode) begin
      bus_word = reverse_bus ? byte_rev : {lsic_pkg::BYTE_ZERO, sample_bus[7:0]};
    end else begin
      bus_word = reverse_bus ? word_rev : sample_bus;
    end
  end

  // ==========================================
  // ddr capture of data and frame marker
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_word_reg <= lsic_pkg::WORD_RST;
      fall_word_reg <= lsic_pkg::WORD_RST;
      frame_rise_reg <= 1'b0;
      frame_fall_reg <= 1'b0;
    end else begin
      if (bus_rise) begin
        rise_word_reg <= bus_word;
        frame_rise_reg <= frame_marker;
      end
      if (bus_fall) begin
        fall_word_reg <= bus_word;
        frame_fall_reg <= frame_marker;
      end
    end
  end

  // frame marker is edge-aligned with data, so a new high starts a frame
  assign frame_start = bus_rise && frame_marker && !frame_rise_reg;

  // fifo writes: every edge in word mode, one paired word per period in byte mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_en_reg <= 1'b0;
      wr_data_reg <= lsic_pkg::WORD_RST;
    end else if (byte_mode) begin
      wr_en_reg <= bus_fall;
      wr_data_reg <= {rise_word_reg[7:0], bus_word[7:0]};
    end else begin
      wr_en_reg <= bus_rise || bus_fall;
      wr_data_reg <= bus_word;
    end
  end

  // frame start either clears the fifo or becomes a sync source
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clear_reg <= 1'b0;
      frame_sync_reg <= 1'b0;
    end else begin
      clear_reg <= frame_start && !frame_is_sync;
      frame_sync_reg <= frame_start && frame_is_sync;
    end
  end

  // block parity over both words of the period plus falling marker
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      parity_error_reg <= 1'b0;
    end else begin
      parity_error_reg <= parity_enable && bus_fall &&
        ((^{rise_word_reg, bus_word, frame_marker}) != odd_parity);
    end
  end

  // ==========================================
  // core side: strobe capture, divider and fifo reads
  assign strobe_event = core_rise && output_sync_strobe && !strobe_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_reg <= 1'b0;
    end else if (core_rise) begin
      strobe_reg <= output_sync_strobe;
    end
  end

  // strobe aligns only in dual-sync mode, otherwise frame sync does
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      align_reg <= 1'b0;
    end else if (dual_sync_mode) begin
      align_reg <= strobe_event;
    end else begin
      align_reg <= frame_start && frame_is_sync;
    end
  end

  // divided clock counter restarts on a dual-sync strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_reg <= lsic_pkg::DIV_RST;
    end else if (dual_sync_mode && strobe_event) begin
      div_cnt_reg <= lsic_pkg::DIV_RST;
    end else if (core_rise) begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end

  // one read per divided period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_en_reg <= 1'b0;
    end else begin
      rd_en_reg <= core_rise && (div_cnt_reg == lsic_pkg::DIV_LAST);
    end
  end

  assign fif.wr_en = wr_en_reg;
  assign fif.wr_data = wr_data_reg;
  assign fif.clear = clear_reg;
  assign fif.align = align_reg;
  assign fif.rd_en = rd_en_reg;

  lsic_sample_fifo u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .fif(fif.fifo)
  );

  // ==========================================
  // registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_out_reg <= lsic_pkg::WORD_RST;
      sample_valid_reg <= 1'b0;
      fifo_overflow_reg <= 1'b0;
      divided_clock_reg <= 1'b0;
    end else begin
      sample_valid_reg <= fif.rd_ok;
      if (fif.rd_ok) begin
        sample_out_reg <= fif.rd_data;
      end
      fifo_overflow_reg <= wr_en_reg && fif.full && !clear_reg;
      divided_clock_reg <= div_cnt_reg[lsic_pkg::DIV_W-1];
    end
  end

  assign sample_out = sample_out_reg;
  assign sample_valid = sample_valid_reg;
  assign frame_sync = frame_sync_reg;
  assign parity_error = parity_error_reg;
  assign fifo_overflow = fifo_overflow_reg;
  assign divided_clock = divided_clock_reg;

  // ==========================================
  // checks
  a_rise_word_capture: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_rise && !byte_mode && !reverse_bus) |=> (rise_word_reg == $past(sample_bus)))
    else $error("rising edge word not captured");
  a_fall_word_capture: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_fall && !byte_mode && !reverse_bus) |=> (fall_word_reg == $past(sample_bus)))
    else $error("falling edge word not captured");
  a_frame_clears_fifo: assert property (@(posedge clk) disable iff (sys_rst)
    (frame_start && !frame_is_sync) |=> (clear_reg && !frame_sync_reg) ##1 fif.empty)
    else $error("frame start did not clear fifo");
  a_parity_flag_cause: assert property (@(posedge clk) disable iff (sys_rst)
    parity_error_reg |-> ($past(bus_fall) && $past(parity_enable)))
    else $error("parity error without falling edge check");
  a_strobe_sampled: assert property (@(posedge clk) disable iff (sys_rst)
    core_rise |=> (strobe_reg == $past(output_sync_strobe)))
    else $error("strobe not sampled on core clock rise");
  a_strobe_aligns: assert property (@(posedge clk) disable iff (sys_rst)
    (dual_sync_mode && strobe_event) |=> (div_cnt_reg == lsic_pkg::DIV_RST) && align_reg)
    else $error("strobe did not align divider and read pointer");
  a_strobe_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (!dual_sync_mode && !(frame_start && frame_is_sync)) |=> !align_reg)
    else $error("alignment outside dual sync mode without frame sync");
  a_byte_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_rise && byte_mode) |=> (rise_word_reg[15:8] == lsic_pkg::BYTE_ZERO))
    else $error("upper byte not zero in byte mode");
  a_reverse_order: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_fall && reverse_bus && !byte_mode) |=>
      ((fall_word_reg[15] == $past(sample_bus[0])) &&
      (fall_word_reg[8] == $past(sample_bus[7])) &&
      (fall_word_reg[0] == $past(sample_bus[15]))))
    else $error("bus not reversed");
  a_read_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    rd_en_reg |=> !rd_en_reg)
    else $error("reads issued back to back");
endmodule
`default_nettype wire

// ### lsic_source_model.sv
// data source model driving the double-data-rate sample bus
`timescale 1ns/1ns
`default_nettype none
module lsic_source_model (
  // clock
  input wire logic clk,
  // sample bus toward the capture block
  output logic sample_bus_clock,
  output logic [15:0] sample_bus,
  output logic frame_marker
);
  // bus clock stands still between edges
  initial begin
    sample_bus_clock = 1'b0;
    sample_bus = 16'h0000;
    frame_marker = 1'b0;
  end
  // one bus edge, marker edge-aligned with data, then stale lines inverted
  task automatic send(input logic [15:0] w, input logic m, input int hold);
    @(posedge clk);
    sample_bus_clock <= ~sample_bus_clock;
    sample_bus <= w;
    frame_marker <= m;
    @(posedge clk);
    sample_bus <= ~w;
    frame_marker <= ~m;
    repeat (hold) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### lsic_capture_test.sv
// self-checking bench for the sample input capture block
`timescale 1ns/1ns
`default_nettype none
module lsic_capture_test;
  logic clk, sys_rst, sample_bus_clock, frame_marker, converter_core_clock, output_sync_strobe;
  logic byte_mode, reverse_bus, frame_is_sync, dual_sync_mode, parity_enable, odd_parity;
  logic [15:0] sample_bus, sample_out, r, f;
  logic sample_valid, frame_sync, parity_error, fifo_overflow, divided_clock, mf, chk_on, core_run;
  logic [15:0] exp_q[$];
  int n_mismatch, n_compared, n_sync, n_perr, n_ovf, cycles, base, pe;
  integer seed;
  // ==========================================
  // design and data source
  lsic_capture dut_u (.clk(clk), .sys_rst(sys_rst), .sample_bus_clock(sample_bus_clock),
    .sample_bus(sample_bus), .frame_marker(frame_marker),
    .converter_core_clock(converter_core_clock), .output_sync_strobe(output_sync_strobe),
    .byte_mode(byte_mode), .reverse_bus(reverse_bus), .frame_is_sync(frame_is_sync),
    .dual_sync_mode(dual_sync_mode), .parity_enable(parity_enable), .odd_parity(odd_parity),
    .sample_out(sample_out), .sample_valid(sample_valid), .frame_sync(frame_sync),
    .parity_error(parity_error), .fifo_overflow(fifo_overflow), .divided_clock(divided_clock));
  lsic_source_model src_u (.clk(clk), .sample_bus_clock(sample_bus_clock),
    .sample_bus(sample_bus), .frame_marker(frame_marker));
  // ==========================================
  // helpers
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] exp_word(input logic [15:0] rw, input logic [15:0] fw);
    logic [15:0] w;
    logic [15:0] v;
    w = byte_mode ? {rw[7:0], fw[7:0]} : fw;
    for (int i = 0; i < 16; i++) v[i] = byte_mode ? w[(i & 8) + 7 - (i & 7)] : w[15 - i];
    return reverse_bus ? v : w;
  endfunction
  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction
  function automatic int hold();
    return int'($unsigned($random(seed)) % 3);
  endfunction
  // one bus clock period; expectations noted before the edges
  task automatic pair(input logic [15:0] rw, input logic [15:0] fw, input logic mr,
    input logic mk, input int h);
    if (byte_mode) begin
      exp_q.push_back(exp_word(rw, fw));
    end else begin
      exp_q.push_back(exp_word(rw, rw));
      exp_q.push_back(exp_word(fw, fw));
    end
    src_u.send(rw, mr, h);
    src_u.send(fw, mk, h);
  endtask
  task automatic do_reset();
    // stop the free-running core clock first so it has a single driver per edge
    if (core_run) begin
      core_run <= 1'b0;
      @(posedge clk);
    end
    sys_rst <= 1'b1;
    converter_core_clock <= 1'b0;
    output_sync_strobe <= 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    exp_q.delete();
    @(posedge clk);
  endtask
  task automatic drain();
    for (int i = 0; i < 500 && exp_q.size() > 0; i++) @(posedge clk);
    cmp(16'(exp_q.size()), 16'h0000);
    repeat (12) @(posedge clk);
  endtask
  task automatic core_rise(input logic s);
    output_sync_strobe <= s;
    converter_core_clock <= 1'b1;
    repeat (3) @(posedge clk);
    converter_core_clock <= 1'b0;
    output_sync_strobe <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // clock, core clock with a random strobe outside dual mode
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (core_run) begin
      converter_core_clock <= ~converter_core_clock;
      output_sync_strobe <= dual_sync_mode ? 1'b0 : 1'($random(seed));
    end
  end
  // monitor: oldest note against each read sample, pulse counts, timeout
  always @(posedge clk) begin
    cycles++;
    n_sync += (frame_sync === 1'b1);
    n_perr += (parity_error === 1'b1);
    n_ovf += (fifo_overflow === 1'b1);
    if (sample_valid === 1'b1 && chk_on) begin
      if (exp_q.size() == 0) cmp(16'(exp_q.size()), 16'h0001);
      else cmp(sample_out, exp_q.pop_front());
    end
    if (cycles > 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    seed = 32'hBDFC55BD;
    {sys_rst, converter_core_clock, output_sync_strobe} = 3'h4;
    {byte_mode, reverse_bus, frame_is_sync, dual_sync_mode, parity_enable, odd_parity} = 6'h00;
    {chk_on, core_run} = 2'h2;
    {cycles, n_mismatch, n_compared, n_sync, n_perr, n_ovf} = '0;
    do_reset();
    // word and byte width, both bit orders
    for (int m = 0; m < 4; m++) begin
      byte_mode <= m[1];
      reverse_bus <= m[0];
      core_run <= 1'b1;
      repeat (2) @(posedge clk);
      repeat (3) pair(rnd(), rnd(), 1'b0, 1'b0, hold());
      drain();
    end
    $display("test width and order done");
    // block parity from the falling-edge marker
    {byte_mode, reverse_bus, parity_enable} <= 3'h1;
    for (int p = 0; p < 2; p++) begin
      odd_parity <= p[0];
      base = n_perr;
      pe = 0;
      @(posedge clk);
      repeat (3) begin
        r = rnd();
        f = rnd();
        mf = 1'($random(seed));
        pe += ((^r ^ ^f ^ mf) != p[0]);
        pair(r, f, 1'b0, mf, hold());
      end
      drain();
      cmp(16'(n_perr - base), 16'(pe));
    end
    parity_enable <= 1'b0;
    $display("test parity done");
    // overfill with reads stopped: two writes dropped
    core_run <= 1'b0;
    base = n_ovf;
    repeat (5) pair(rnd(), rnd(), 1'b0, 1'b0, hold());
    void'(exp_q.pop_back());
    void'(exp_q.pop_back());
    repeat (4) @(posedge clk);
    cmp(16'(n_ovf - base), 16'h0002);
    core_run <= 1'b1;
    drain();
    $display("test overflow done");
    // frame start clears the fifo, its own word lost
    core_run <= 1'b0;
    pair(rnd(), rnd(), 1'b0, 1'b0, hold());
    exp_q.delete();
    src_u.send(rnd(), 1'b1, 4);
    r = rnd();
    exp_q.push_back(r);
    src_u.send(r, 1'b0, hold());
    pair(rnd(), rnd(), 1'b0, 1'b0, hold());
    core_run <= 1'b1;
    drain();
    $display("test frame clear done");
    // frame as sync source: one pulse per new start only
    do_reset();
    frame_is_sync <= 1'b1;
    chk_on <= 1'b0;
    base = n_sync;
    for (int i = 0; i < 6; i++) pair(rnd(), rnd(), 1'(6'h2E >> i), 1'b0, hold());
    repeat (6) @(posedge clk);
    cmp(16'(n_sync - base), 16'h0002);
    $display("test frame sync done");
    // strobe at core clock rise resets divider only in dual mode
    for (int d = 0; d < 2; d++) begin
      do_reset();
      frame_is_sync <= 1'b0;
      dual_sync_mode <= d[0];
      core_rise(1'b0);
      core_rise(1'b0);
      cmp(16'(divided_clock), 16'h0001);
      core_rise(1'b1);
      repeat (6) @(posedge clk);
      cmp(16'(divided_clock), d ? 16'h0000 : 16'h0001);
    end
    $display("test strobe done");
    stop_test();
  end
endmodule
`default_nettype wire
